// ### sim/illw_chk.sv
`timescale 1ns/1ns
module illw_chk(
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Event request
	input wire ev_valid,
	input wire ev_ready,
	input wire [1:0] ev_kind,
	input wire [4:0] irq_category,
	input wire [1:0] irq_logical_port,
	input wire frame_left_port,
	// Entry
	input wire [31:0] entry_w0,
	input wire [31:0] entry_w2,
	input wire entry_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence acc_s; ev_valid && ev_ready; endsequence
	sequence pulse_s; !entry_irq ##1 entry_irq ##1 !entry_irq; endsequence
	chk_port_plus: assert property (acc_s |=> entry_w0[26:24] == $past(irq_logical_port) + 3'h1)
		else $error("port");
	chk_class_copy: assert property (acc_s |=> entry_w0[31:27] == $past(irq_category)) else $error("class");
	chk_irq_late: assert property (acc_s |=> pulse_s) else $error("irq");
	chk_busy_gap: assert property (acc_s |=> !ev_ready ##1 ev_ready) else $error("busy");
	chk_rx_head: assert property (acc_s ##0 ev_kind == 2'h0 |=> entry_w2[31:28] == 4'h7)
		else $error("rx head");
	chk_tx_frame: assert property (acc_s ##0 ev_kind == 2'h1 |=> entry_w2[19] == $past(frame_left_port))
		else $error("frame");
	chk_words_hold: assert property (entry_irq |-> $stable(entry_w0) && $stable(entry_w2)) else $error("hold");
	chk_irq_cause: assert property (entry_irq |-> !$past(ev_ready)) else $error("cause");
endmodule // illw_chk
bind illw_writer illw_chk chk_u(.*);

// ### sim/illw_host.sv
`timescale 1ns/1ns
module illw_host(
	// From the device
	input wire pclk,
	input wire entry_irq,
	input wire [31:0] entry_w1,
	input wire [31:0] entry_w2,
	// As read by software
	output logic [31:0] h1,
	output logic [31:0] h2
);
	// Read only on the interrupt, so a half-built entry is never seen
	always @(posedge pclk) if (entry_irq) {h1, h2} <= {entry_w1, entry_w2};
endmodule // illw_host

// ### sim/illw_writer_tb.sv
`timescale 1ns/1ns
`include "illw_defs.vh"
module illw_writer_tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ev_valid = 0, ev_phy_b = 0, ev_trg_capture = 0;
	logic sim_pkt_irq, gen_cond_hit, rx_cond_hit, frame_left_port, trig_valid, buf_full_ev, buf_half_ev, mon_start_ev;
	logic mon_stop_ev, dec_halted, udp_msg_written, ev_ready, pready, pslverr, entry_irq;
	logic [1:0] ev_kind = 0, irq_logical_port = 0;
	logic [2:0] ev_op = 0;
	logic [4:0] irq_category = 0;
	logic [5:0] transmit_instruction_kind = 6'h2b;
	logic [7:0] paddr = 0, ev_tcb_index = 8'h5a;
	logic [10:0] c = 0;
	logic [23:0] ev_info = 24'h0a5c3e;
	logic [31:0] pwdata = 0, ev_vlink = 32'hc0de0001, ev_admin_ptr = 32'h00004ac0, prdata, rd, h1, h2;
	logic [31:0] entry_w0, entry_w1, entry_w2, entry_w3;
	int mismatches = 0, compares = 0, n, j;
	illw_writer dut_u(.*);
	illw_host host_u(.pclk(pclk), .entry_irq(entry_irq), .entry_w1(entry_w1), .entry_w2(entry_w2), .h1(h1), .h2(h2));
	assign {sim_pkt_irq, gen_cond_hit, rx_cond_hit, frame_left_port, trig_valid, buf_full_ev, buf_half_ev,
		mon_start_ev, mon_stop_ev, dec_halted, udp_msg_written} = c;
	always #10 pclk = ~pclk;
	task automatic cmp(input logic [31:0] g, e);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic give_verdict;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Ready is looked at mid-cycle, then the request is taken at the next rising edge
	task automatic waitfor(input bit which);
		n = 0;
		@(negedge pclk);
		while ((which ? pready : ev_ready) !== 1'b1 && n < 40) begin
			@(negedge pclk);
			n++;
		end
		if (n >= 40) begin
			mismatches++;
			give_verdict();
		end
		@(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		waitfor(1'b1);
		rd = prdata;
		{psel, penable} <= 2'h0;
	endtask
	task automatic ev(input logic [1:0] k, input logic [4:0] cat, input logic [2:0] op, input logic [10:0] cs,
		input logic pb, cap);
		@(posedge pclk);
		{ev_valid, ev_kind, irq_category, ev_op, c, ev_phy_b, ev_trg_capture} <= {1'b1, k, cat, op, cs, pb, cap};
		irq_logical_port <= irq_logical_port + 2'h1;
		waitfor(1'b0);
		ev_valid <= 1'b0;
		// Host copy lands one edge after the pulse
		repeat (3) @(posedge pclk);
		cmp(entry_w0, {cat, {1'b0, irq_logical_port} + 3'h1, ev_info});
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		cmp(entry_w0, 32'h0);
		for (j = 1; j < 11; j++) begin
			ev(`ILLW_EV_RX, j[0] ? `ILLW_CLS_DEC2 : `ILLW_CLS_DEC1, 3'h0, 11'h1 << j, j[0], 1'b0);
			cmp(h1, ev_vlink);
			cmp(h2, {3'h3, 1'b1, |c[10:8], c[6], c[5] | c[4], c[3:1], 13'h0, j[0], ev_tcb_index});
		end
		$display("rx done");
		for (j = 0; j < 3; j++) begin
			ev(`ILLW_EV_TX, `ILLW_CLS_DEC1, j[2:0], {j[0], j[1], 1'b0, ~j[0], 7'h0}, 1'b1, 1'b0);
			cmp(h2, {j[2:0], 1'b1, j[0] | j[1], 1'b0, transmit_instruction_kind, ~j[0], 11'h1, 8'h0});
		end
		$display("tx done");
		for (j = 0; j < 2; j++) begin
			ev(`ILLW_EV_TRG, `ILLW_CLS_TRG, 3'h0, {10'h0, ~j[0]}, 1'b0, j[0]);
			cmp(h1, {j[0] ? `ILLW_TRG_CAP : `ILLW_TRG_UDP, 2'h2, ~j[0], 26'h0});
		end
		cmp(h2, ev_admin_ptr);
		for (j = 0; j < 2; j++) ev(`ILLW_EV_OTHER, 5'h1 << j, 3'h0, 11'h0, 1'b0, 1'b0);
		cmp(h2, 32'h0);
		$display("class done");
		apb(1'b1, `ILLW_A_CTRL, 32'h3);
		apb(1'b0, `ILLW_A_CTRL, 32'h0);
		cmp(rd, 32'h3);
		ev(`ILLW_EV_RX, `ILLW_CLS_DEC1, 3'h0, 11'h10, 1'b1, 1'b0);
		cmp(h2, {4'h7, 20'h0, ev_tcb_index});
		apb(1'b0, `ILLW_A_STAT, 32'h0);
		cmp(rd, 32'h12);
		apb(1'b0, 8'h40, 32'h0);
		cmp(rd, 32'h0);
		cmp(entry_w3 | {31'h0, pslverr}, 32'h0);
		$display("regs done");
		give_verdict();
	end
endmodule // illw_writer_tb

// ### src/illw_defs.vh
`ifndef ILLW_DEFS_VH
`define ILLW_DEFS_VH
// APB register byte offsets
`define ILLW_A_CTRL 8'h00
`define ILLW_A_STAT 8'h04
`define ILLW_A_W0 8'h08
`define ILLW_A_W1 8'h0c
`define ILLW_A_W2 8'h10
`define ILLW_A_W3 8'h14
// Control bits
`define ILLW_C_REDUN 0
`define ILLW_C_SELCAP 1
// Source class codes, one-hot
`define ILLW_CLS_DMA 5'h01
`define ILLW_CLS_CMD 5'h02
`define ILLW_CLS_TRG 5'h04
`define ILLW_CLS_DEC1 5'h08
`define ILLW_CLS_DEC2 5'h10
// Word 0 layout
`define ILLW_W0_CLS_LSB 27
`define ILLW_W0_PORT_LSB 24
// Trigger word 1 codes and bits
`define ILLW_TRG_UDP 3'h4
`define ILLW_TRG_CAP 3'h5
`define ILLW_W1_TYPE_LSB 29
`define ILLW_UPD_BIT 28
`define ILLW_W1_UBF_BIT 26
// Word 2 operation codes
`define ILLW_OP_SIM 3'h0
`define ILLW_OP_REPLAY 3'h1
`define ILLW_OP_GEN 3'h2
`define ILLW_OP_RXMN 3'h3
`define ILLW_W2_OP_LSB 29
`define ILLW_W2_PACKET_CONDITION_FLAG_BIT 27
`define ILLW_W2_FTI_BIT 19
`define ILLW_W2_TRANSMIT_INSTRUCTION_KIND_LSB 20
`define ILLW_W2_PHY_LSB 8
// Physical port codes
`define ILLW_PHY_A 8'h00
`define ILLW_PHY_B 8'h01
// Event kinds
`define ILLW_EV_RX 2'h0
`define ILLW_EV_TX 2'h1
`define ILLW_EV_TRG 2'h2
`define ILLW_EV_OTHER 2'h3
`endif

// ### src/illw_writer.v
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "illw_defs.vh"
module illw_writer #(
	parameter TRANSMIT_INSTRUCTION_KIND_W = 6
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Event request
	input wire ev_valid,
	output wire ev_ready,
	input wire [1:0] ev_kind,
	input wire [4:0] irq_category,
	input wire [1:0] irq_logical_port,
	input wire [23:0] ev_info,
	input wire ev_phy_b,
	input wire [2:0] ev_op,
	input wire [31:0] ev_vlink,
	input wire ev_trg_capture,
	input wire [31:0] ev_admin_ptr,
	input wire [7:0] ev_tcb_index,
	input wire [TRANSMIT_INSTRUCTION_KIND_W-1:0] transmit_instruction_kind,
	// Event causes
	input wire sim_pkt_irq,
	input wire gen_cond_hit,
	input wire rx_cond_hit,
	input wire frame_left_port,
	input wire trig_valid,
	input wire buf_full_ev,
	input wire buf_half_ev,
	input wire mon_start_ev,
	input wire mon_stop_ev,
	input wire dec_halted,
	input wire udp_msg_written,
	// Log entry out
	output reg [31:0] entry_w0,
	output reg [31:0] entry_w1,
	output reg [31:0] entry_w2,
	output reg [31:0] entry_w3,
	output reg entry_irq
);
	reg [1:0] ctrl_r;
	reg [31:0] w0_nxt, w1_nxt, w2_nxt;
	reg busy_r;
	reg [15:0] count_r;
	wire packet_condition_flag, monitor_trigger_flag, buffer_full_flag;
	wire monitor_start_flag, monitor_stop_flag, receiver_overflow_flag;
	wire frame_sent_flag, update_flag, udp_buffer_event_flag;
	wire [7:0] phy_port;
	wire wr_en, rd_en;

	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;
	// One entry at a time; host must pick it up via the pulse
	assign ev_ready = ~busy_r;

	assign packet_condition_flag = sim_pkt_irq | gen_cond_hit | rx_cond_hit;
	assign frame_sent_flag = frame_left_port;
	assign monitor_trigger_flag = trig_valid;
	// Half-full is dropped in selective capture mode only, kept in standard mode
	assign buffer_full_flag = buf_full_ev | (buf_half_ev & ~ctrl_r[`ILLW_C_SELCAP]);
	assign monitor_start_flag = mon_start_ev;
	assign monitor_stop_flag = mon_stop_ev;
	assign receiver_overflow_flag = dec_halted;
	assign update_flag = 1'b1;
	assign udp_buffer_event_flag = udp_msg_written;
	assign phy_port = (ctrl_r[`ILLW_C_REDUN] | ~ev_phy_b) ? `ILLW_PHY_A : `ILLW_PHY_B;

	always @* begin
		w0_nxt = 32'h0;
		w0_nxt[31:`ILLW_W0_CLS_LSB] = irq_category;
		w0_nxt[26:`ILLW_W0_PORT_LSB] = {1'b0, irq_logical_port} + 3'h1;
		w0_nxt[23:0] = ev_info;
		w1_nxt = 32'h0;
		w2_nxt = 32'h0;
		case (ev_kind)
		`ILLW_EV_RX: begin
			if ((irq_category == `ILLW_CLS_DEC1) || (irq_category == `ILLW_CLS_DEC2))
				w1_nxt = ev_vlink;
			w2_nxt[31:`ILLW_W2_OP_LSB] = `ILLW_OP_RXMN;
			w2_nxt[`ILLW_UPD_BIT] = update_flag;
			w2_nxt[27:22] = {packet_condition_flag, monitor_trigger_flag, buffer_full_flag,
				monitor_start_flag, monitor_stop_flag, receiver_overflow_flag};
			w2_nxt[15:`ILLW_W2_PHY_LSB] = phy_port;
			w2_nxt[7:0] = ev_tcb_index;
		end
		`ILLW_EV_TX: begin
			// Op code caller-chosen among sim/replay/generic/rx monitor; codes above rx monitor become generic
			w2_nxt[31:`ILLW_W2_OP_LSB] = (ev_op > `ILLW_OP_RXMN) ? `ILLW_OP_GEN : ev_op;
			w2_nxt[`ILLW_UPD_BIT] = update_flag;
			w2_nxt[`ILLW_W2_PACKET_CONDITION_FLAG_BIT] = packet_condition_flag;
			w2_nxt[`ILLW_W2_TRANSMIT_INSTRUCTION_KIND_LSB +: TRANSMIT_INSTRUCTION_KIND_W] = transmit_instruction_kind;
			w2_nxt[`ILLW_W2_FTI_BIT] = frame_sent_flag;
			w2_nxt[15:`ILLW_W2_PHY_LSB] = phy_port;
		end
		`ILLW_EV_TRG: begin
			w1_nxt[31:`ILLW_W1_TYPE_LSB] = ev_trg_capture ? `ILLW_TRG_CAP : `ILLW_TRG_UDP;
			w1_nxt[`ILLW_UPD_BIT] = update_flag;
			w1_nxt[`ILLW_W1_UBF_BIT] = udp_buffer_event_flag;
			if (ev_trg_capture)
				w2_nxt = ev_admin_ptr;
		end
		default: begin
		end
		endcase
	end

	// Words land first, pulse follows one edge later
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_r <= 1'b0;
			entry_irq <= 1'b0;
			entry_w0 <= 32'h0;
			entry_w1 <= 32'h0;
			entry_w2 <= 32'h0;
			entry_w3 <= 32'h0;
			count_r <= 16'h0;
		end else begin
			entry_irq <= busy_r;
			busy_r <= 1'b0;
			if (ev_valid & ~busy_r) begin
				entry_w0 <= w0_nxt;
				entry_w1 <= w1_nxt;
				entry_w2 <= w2_nxt;
				entry_w3 <= 32'h0;
				busy_r <= 1'b1;
				count_r <= count_r + 16'h1;
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= 2'h0;
			prdata <= 32'h0;
		end else begin
			if (wr_en && paddr == `ILLW_A_CTRL)
				ctrl_r <= pwdata[1:0];
			if (rd_en) begin
				case (paddr)
				`ILLW_A_CTRL: prdata <= {30'h0, ctrl_r};
				`ILLW_A_STAT: prdata <= {15'h0, busy_r, count_r};
				`ILLW_A_W0: prdata <= entry_w0;
				`ILLW_A_W1: prdata <= entry_w1;
				`ILLW_A_W2: prdata <= entry_w2;
				`ILLW_A_W3: prdata <= entry_w3;
				default: prdata <= 32'h0;
				endcase
			end
		end
	end
endmodule // illw_writer
